// ===== hdl/csr_pkg.sv
package csr_pkg;

    // reset vector table
    localparam logic [31:0] VEC_BASE_RST = 32'h0000_0000;
    localparam logic [31:0] VEC_SP_OFS = 32'h0000_0000;
    localparam logic [31:0] VEC_PC_OFS = 32'h0000_0004;

    // reset values
    localparam logic [31:0] RETURN_LINK_RST = 32'hffff_ffff;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [5:0] EXC_THREAD = 6'h00;
    localparam logic CTRL_RST = 1'b0;

    // full-descending stack step
    localparam logic [31:0] STACK_STEP = 32'h0000_0004;

    // status word, exception mask and control field positions
    localparam int FLAGS_HI = 31;
    localparam int FLAGS_LO = 28;
    localparam int TBIT_POS = 24;
    localparam int EXC_HI = 5;
    localparam int EXC_LO = 0;
    localparam int SPSEL_POS = 1;
    localparam int EXC_MASK_POS = 0;

    // core register index space
    localparam int NUM_GPR = 13;
    localparam logic [3:0] REG_SP = 4'hd;
    localparam logic [3:0] REG_LR = 4'he;
    localparam logic [3:0] REG_PC = 4'hf;

    // status instruction register names
    localparam logic [7:0] SR_FLAGS = 8'h00;
    localparam logic [7:0] SR_ALL = 8'h03;
    localparam logic [7:0] SR_EXC = 8'h05;
    localparam logic [7:0] SR_STATE = 8'h06;
    localparam logic [7:0] SR_EXC_STATE = 8'h07;
    localparam logic [7:0] SR_MAIN_SP = 8'h08;
    localparam logic [7:0] SR_PROC_SP = 8'h09;
    localparam logic [7:0] SR_EXC_MASK = 8'h10;
    localparam logic [7:0] SR_CONTROL = 8'h14;
    // view selector bits
    localparam int VIEW_EXC_BIT = 0;
    localparam int VIEW_NOFLAG_BIT = 2;

    typedef enum logic [1:0] {
        BOOT_SP = 2'b00,
        BOOT_PC = 2'b01,
        BOOT_RUN = 2'b10
    } csr_boot_t;

endpackage

// ===== hdl/csr_stack_banks.sv
`timescale 1ns/10ps
module csr_stack_banks (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_use_process,
    input wire logic i_load_main,
    input wire logic [31:0] i_load_data,
    input wire logic i_wr_main,
    input wire logic i_wr_proc,
    input wire logic i_wr_active,
    input wire logic [31:0] i_wdata,
    input wire logic i_push,
    input wire logic i_pop,
    output logic [31:0] o_main_sp,
    output logic [31:0] o_process_sp,
    output logic [31:0] o_active_sp
);
    typedef struct packed {
        logic [31:0] main_sp;
        logic [31:0] proc_sp;
    } csr_sp_t;

    csr_sp_t st;
    csr_sp_t next_st;
    logic [31:0] act;

    always_comb begin
        next_st = st;
        act = i_use_process ? st.proc_sp : st.main_sp;
        if (i_wr_active) begin
            act = i_wdata;
        end else if (i_push) begin
            act = act - csr_pkg::STACK_STEP;
        end else if (i_pop) begin
            act = act + csr_pkg::STACK_STEP;
        end
        if (i_use_process) begin
            next_st.proc_sp = act;
        end else begin
            next_st.main_sp = act;
        end
        if (i_wr_main) begin
            next_st.main_sp = i_wdata;
        end
        if (i_wr_proc) begin
            next_st.proc_sp = i_wdata;
        end
        if (i_load_main) begin
            next_st.main_sp = i_load_data;
        end
        if (!i_nrst) begin
            next_st.main_sp = csr_pkg::WORD_ZERO;
            next_st.proc_sp = csr_pkg::WORD_ZERO;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        st <= next_st;
    end

    assign o_main_sp = st.main_sp;
    assign o_process_sp = st.proc_sp;
    assign o_active_sp = i_use_process ? st.proc_sp : st.main_sp;
endmodule // csr_stack_banks

// ===== hdl/csr_status_word.sv
`timescale 1ns/10ps
module csr_status_word (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_load_t,
    input wire logic i_t_value,
    input wire logic i_flags_we,
    input wire logic [3:0] i_flags,
    input wire logic i_sr_wr,
    input wire logic [7:0] i_sr_sel,
    input wire logic [31:0] i_sr_wdata,
    input wire logic i_exc_entry,
    input wire logic [5:0] i_exc_num,
    input wire logic i_exc_return,
    input wire logic [31:0] i_ret_status,
    output logic [31:0] o_status_word,
    output logic [31:0] o_view_rdata,
    output logic [5:0] o_exc_num,
    output logic o_tbit
);
    typedef struct packed {
        logic [3:0] flags;
        logic [5:0] exc_num;
        logic tbit;
    } csr_sw_t;

    csr_sw_t st;
    csr_sw_t next_st;
    logic is_view;
    logic has_flags;

    always_comb begin
        next_st = st;
        is_view = (i_sr_sel[7:3] == 5'h00) && (i_sr_sel != 8'h04);
        has_flags = is_view && !i_sr_sel[csr_pkg::VIEW_NOFLAG_BIT];
        if (i_flags_we) begin
            next_st.flags = i_flags;
        end
        // exception and state bits are never written here
        if (i_sr_wr && has_flags) begin
            next_st.flags =
                i_sr_wdata[csr_pkg::FLAGS_HI:csr_pkg::FLAGS_LO];
        end
        if (i_exc_entry) begin
            next_st.exc_num = i_exc_num;
        end else if (i_exc_return) begin
            next_st.exc_num = csr_pkg::EXC_THREAD;
            next_st.flags =
                i_ret_status[csr_pkg::FLAGS_HI:csr_pkg::FLAGS_LO];
            next_st.tbit = i_ret_status[csr_pkg::TBIT_POS];
        end
        if (i_load_t) begin
            next_st.tbit = i_t_value;
        end
        if (!i_nrst) begin
            next_st.flags = 4'h0;
            next_st.exc_num = csr_pkg::EXC_THREAD;
            next_st.tbit = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        st <= next_st;
    end

    always_comb begin
        o_status_word = csr_pkg::WORD_ZERO;
        o_status_word[csr_pkg::FLAGS_HI:csr_pkg::FLAGS_LO] = st.flags;
        o_status_word[csr_pkg::TBIT_POS] = st.tbit;
        o_status_word[csr_pkg::EXC_HI:csr_pkg::EXC_LO] = st.exc_num;
        // execution state always reads as zero through a view
        o_view_rdata = csr_pkg::WORD_ZERO;
        if (has_flags) begin
            o_view_rdata[csr_pkg::FLAGS_HI:csr_pkg::FLAGS_LO] = st.flags;
        end
        if (is_view && i_sr_sel[csr_pkg::VIEW_EXC_BIT]) begin
            o_view_rdata[csr_pkg::EXC_HI:csr_pkg::EXC_LO] = st.exc_num;
        end
    end

    assign o_exc_num = st.exc_num;
    assign o_tbit = st.tbit;
endmodule // csr_status_word

// ===== hdl/csr_core_state.sv
`timescale 1ns/10ps
module csr_core_state #(
    parameter logic [31:0] VEC_BASE = csr_pkg::VEC_BASE_RST
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    output logic o_mem_req,
    output logic [31:0] o_mem_addr,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output logic o_core_run,
    input wire logic i_reg_we,
    input wire logic [3:0] i_reg_waddr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic [3:0] i_reg_raddr,
    output logic [31:0] o_reg_rdata,
    input wire logic i_pc_we,
    input wire logic [31:0] i_pc_wdata,
    input wire logic i_pc_tload,
    output logic [31:0] o_program_counter,
    output logic [31:0] o_return_link,
    input wire logic i_push,
    input wire logic [31:0] i_push_data,
    input wire logic i_pop,
    output logic o_store_valid,
    output logic [31:0] o_store_addr,
    output logic [31:0] o_store_data,
    input wire logic i_flags_we,
    input wire logic [3:0] i_flags,
    input wire logic i_sr_wr,
    input wire logic [7:0] i_sr_sel,
    input wire logic [31:0] i_sr_wdata,
    output logic [31:0] o_sr_rdata,
    input wire logic i_exc_entry,
    input wire logic [5:0] i_exc_num,
    input wire logic [31:0] i_exc_vector,
    input wire logic i_exc_return,
    input wire logic [31:0] i_ret_status,
    output logic o_handler_mode,
    output logic [31:0] o_active_sp,
    output logic [31:0] o_combined_status_word,
    output logic o_tbit,
    output logic o_exc_mask,
    output logic o_spsel
);
    if (VEC_BASE[1:0] != 2'b00) begin : g_bad_base
        $error("vector base must be word aligned");
    end

    typedef struct packed {
        csr_pkg::csr_boot_t boot;
        logic [31:0] mem_addr;
        logic [csr_pkg::NUM_GPR-1:0][31:0] gpr;
        logic [31:0] link;
        logic [31:0] pc;
        logic exc_mask;
        logic spsel;
        logic [31:0] rdata;
        logic [31:0] sr_rdata;
        logic store_valid;
        logic [31:0] store_addr;
        logic [31:0] store_data;
    } csr_core_t;

    csr_core_t st;
    csr_core_t next_st;
    logic run;
    logic handler;
    logic use_process;
    logic [31:0] main_sp;
    logic [31:0] proc_sp;
    logic [31:0] active_sp;
    logic [31:0] stat_word;
    logic [31:0] view_rdata;
    logic [5:0] exc_num;
    logic tbit;
    logic load_main;
    logic load_t;
    logic t_value;
    logic sr_wr_run;
    logic wr_sp;

    ////////////////////////////////////////////////////////////////////
    // mode and stack selection

    assign run = (st.boot == csr_pkg::BOOT_RUN);
    assign handler = (exc_num != csr_pkg::EXC_THREAD);
    assign use_process = !handler && st.spsel;
    assign load_main = (st.boot == csr_pkg::BOOT_SP) && i_mem_ack;
    // no privilege gating on any status access
    assign sr_wr_run = run && i_sr_wr;
    assign wr_sp = run && i_reg_we && (i_reg_waddr == csr_pkg::REG_SP);

    always_comb begin
        load_t = 1'b0;
        t_value = 1'b0;
        if ((st.boot == csr_pkg::BOOT_PC) && i_mem_ack) begin
            load_t = 1'b1;
            t_value = i_mem_rdata[0];
        end else if (run && i_exc_entry) begin
            load_t = 1'b1;
            t_value = i_exc_vector[0];
        end else if (run && i_pc_we && i_pc_tload) begin
            load_t = 1'b1;
            t_value = i_pc_wdata[0];
        end
    end

    csr_stack_banks u_stack (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_use_process(use_process),
        .i_load_main(load_main),
        .i_load_data(i_mem_rdata),
        .i_wr_main(sr_wr_run && (i_sr_sel == csr_pkg::SR_MAIN_SP)),
        .i_wr_proc(sr_wr_run && (i_sr_sel == csr_pkg::SR_PROC_SP)),
        .i_wr_active(wr_sp),
        .i_wdata(wr_sp ? i_reg_wdata : i_sr_wdata),
        .i_push(run && i_push),
        .i_pop(run && i_pop),
        .o_main_sp(main_sp),
        .o_process_sp(proc_sp),
        .o_active_sp(active_sp)
    );

    csr_status_word u_status (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_load_t(load_t),
        .i_t_value(t_value),
        .i_flags_we(run && i_flags_we),
        .i_flags(i_flags),
        .i_sr_wr(sr_wr_run),
        .i_sr_sel(i_sr_sel),
        .i_sr_wdata(i_sr_wdata),
        .i_exc_entry(run && i_exc_entry),
        .i_exc_num(i_exc_num),
        .i_exc_return(run && i_exc_return),
        .i_ret_status(i_ret_status),
        .o_status_word(stat_word),
        .o_view_rdata(view_rdata),
        .o_exc_num(exc_num),
        .o_tbit(tbit)
    );

    ////////////////////////////////////////////////////////////////////
    // boot sequence, register bank and read ports

    always_comb begin
        next_st = st;
        next_st.store_valid = 1'b0;
        unique case (st.boot)
            csr_pkg::BOOT_SP: begin
                if (i_mem_ack) begin
                    next_st.mem_addr = VEC_BASE + csr_pkg::VEC_PC_OFS;
                    next_st.boot = csr_pkg::BOOT_PC;
                end
            end
            csr_pkg::BOOT_PC: begin
                if (i_mem_ack) begin
                    next_st.pc = {i_mem_rdata[31:1], 1'b0};
                    next_st.boot = csr_pkg::BOOT_RUN;
                end
            end
            csr_pkg::BOOT_RUN: begin
                if (i_reg_we && (i_reg_waddr < 4'(csr_pkg::NUM_GPR))) begin
                    next_st.gpr[i_reg_waddr] = i_reg_wdata;
                end
                if (i_reg_we && (i_reg_waddr == csr_pkg::REG_LR)) begin
                    next_st.link = i_reg_wdata;
                end
                if (i_exc_entry) begin
                    next_st.pc = {i_exc_vector[31:1], 1'b0};
                end else if (i_pc_we) begin
                    next_st.pc = {i_pc_wdata[31:1], 1'b0};
                end else if (i_reg_we && (i_reg_waddr == csr_pkg::REG_PC))
                begin
                    next_st.pc = {i_reg_wdata[31:1], 1'b0};
                end
                if (i_sr_wr && (i_sr_sel == csr_pkg::SR_EXC_MASK)) begin
                    next_st.exc_mask = i_sr_wdata[csr_pkg::EXC_MASK_POS];
                end
                if (i_sr_wr && (i_sr_sel == csr_pkg::SR_CONTROL)) begin
                    next_st.spsel = i_sr_wdata[csr_pkg::SPSEL_POS];
                end
                if (i_push && !wr_sp) begin
                    next_st.store_valid = 1'b1;
                    next_st.store_addr = active_sp - csr_pkg::STACK_STEP;
                    next_st.store_data = i_push_data;
                end
            end
            default: begin
                next_st.boot = csr_pkg::BOOT_SP;
            end
        endcase
        unique case (i_reg_raddr)
            csr_pkg::REG_SP: next_st.rdata = active_sp;
            csr_pkg::REG_LR: next_st.rdata = st.link;
            csr_pkg::REG_PC: next_st.rdata = st.pc;
            default: next_st.rdata = st.gpr[i_reg_raddr];
        endcase
        unique case (i_sr_sel)
            csr_pkg::SR_MAIN_SP: next_st.sr_rdata = main_sp;
            csr_pkg::SR_PROC_SP: next_st.sr_rdata = proc_sp;
            csr_pkg::SR_EXC_MASK: begin
                next_st.sr_rdata = csr_pkg::WORD_ZERO;
                next_st.sr_rdata[csr_pkg::EXC_MASK_POS] = st.exc_mask;
            end
            csr_pkg::SR_CONTROL: begin
                next_st.sr_rdata = csr_pkg::WORD_ZERO;
                next_st.sr_rdata[csr_pkg::SPSEL_POS] = st.spsel;
            end
            default: next_st.sr_rdata = view_rdata;
        endcase
        if (!i_nrst) begin
            next_st.boot = csr_pkg::BOOT_SP;
            next_st.mem_addr = VEC_BASE + csr_pkg::VEC_SP_OFS;
            next_st.link = csr_pkg::RETURN_LINK_RST;
            next_st.pc = csr_pkg::WORD_ZERO;
            next_st.exc_mask = csr_pkg::CTRL_RST;
            next_st.spsel = csr_pkg::CTRL_RST;
            next_st.rdata = csr_pkg::WORD_ZERO;
            next_st.sr_rdata = csr_pkg::WORD_ZERO;
            next_st.store_valid = 1'b0;
            next_st.store_addr = csr_pkg::WORD_ZERO;
            next_st.store_data = csr_pkg::WORD_ZERO;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        st <= next_st;
    end

    assign o_mem_req = (st.boot == csr_pkg::BOOT_SP) ||
                       (st.boot == csr_pkg::BOOT_PC);
    assign o_mem_addr = st.mem_addr;
    assign o_core_run = run;
    assign o_reg_rdata = st.rdata;
    assign o_program_counter = st.pc;
    assign o_return_link = st.link;
    assign o_store_valid = st.store_valid;
    assign o_store_addr = st.store_addr;
    assign o_store_data = st.store_data;
    assign o_sr_rdata = st.sr_rdata;
    assign o_handler_mode = handler;
    assign o_active_sp = active_sp;
    assign o_combined_status_word = stat_word;
    assign o_tbit = tbit;
    assign o_exc_mask = st.exc_mask;
    assign o_spsel = st.spsel;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    a_thread_at_run: assert property ($rose(run) |-> !handler)
        else $error("core left reset outside thread mode");
    a_return_thread: assert property (
        run && i_exc_return && !i_exc_entry |=> !handler)
        else $error("exception return did not reach thread mode");
    a_handler_main: assert property (
        handler |-> active_sp == main_sp)
        else $error("handler mode not on main stack");
    a_thread_select: assert property (
        !handler |-> active_sp == (st.spsel ? proc_sp : main_sp))
        else $error("thread stack select wrong");
    a_push_store: assert property (
        run && i_push && !wr_sp |=> o_store_valid &&
        o_store_addr == $past(active_sp) - 32'h0000_0004)
        else $error("push did not pre-decrement");
    a_main_sp_load: assert property (
        st.boot == csr_pkg::BOOT_SP && i_mem_ack |=>
        main_sp == $past(i_mem_rdata) && o_mem_addr == VEC_BASE + 32'h4)
        else $error("main stack pointer not loaded");
    a_link_reset: assert property (
        !run |-> o_return_link == 32'hffff_ffff)
        else $error("return link not all ones");
    a_vector_load: assert property (
        st.boot == csr_pkg::BOOT_PC && i_mem_ack |=>
        o_program_counter == {$past(i_mem_rdata[31:1]), 1'b0} &&
        stat_word[24] == $past(i_mem_rdata[0]))
        else $error("reset vector not loaded");
    a_exc_write_ign: assert property (
        run && i_sr_wr && !i_exc_entry && !i_exc_return |=>
        $stable(exc_num))
        else $error("exception number changed by write");
    a_state_reads0: assert property (
        i_sr_sel == csr_pkg::SR_STATE |=> o_sr_rdata == 32'h0)
        else $error("execution state visible to software");
    a_boot_order: assert property (
        $rose(run) |-> $past(st.boot) == csr_pkg::BOOT_PC)
        else $error("run before vector fetch");

    c_boot_done: cover property ($rose(run));
    c_exc_entry: cover property (run && i_exc_entry ##1 handler);
    c_proc_push: cover property (run && use_process && i_push);
endmodule // csr_core_state

// ===== verification/csr_vec_mem.sv
`timescale 1ns/10ps
module csr_vec_mem #(
    parameter logic [31:0] SP_WORD = 32'h2000_1000,
    parameter logic [31:0] PC_WORD = 32'h0000_0101
) (
    input wire logic i_sys_clk,
    input wire logic [3:0] i_delay,
    input wire logic i_mem_req,
    input wire logic [31:0] i_mem_addr,
    output logic o_mem_ack,
    output logic [31:0] o_mem_rdata
);
    logic [3:0] wait_cnt = 4'h0;
    logic [31:0] log_addr [0:1];
    initial begin
        o_mem_ack = 1'b0;
        o_mem_rdata = 32'h0000_0000;
    end
    // the pc vector keeps bit 0 set so the state bit loads as one
    always @(posedge i_sys_clk) begin
        if (i_mem_req && !o_mem_ack && wait_cnt >= i_delay) begin
            o_mem_ack <= 1'b1;
            wait_cnt <= 4'h0;
            log_addr[0] <= log_addr[1];
            log_addr[1] <= i_mem_addr;
            if (i_mem_addr == 32'h0000_0000) begin
                o_mem_rdata <= SP_WORD;
            end else if (i_mem_addr == 32'h0000_0004) begin
                o_mem_rdata <= PC_WORD;
            end else begin
                o_mem_rdata <= ~o_mem_rdata;
            end
        end else begin
            // stale data is scrambled outside an ack
            o_mem_ack <= 1'b0;
            o_mem_rdata <= ~o_mem_rdata;
            // an unknown request before the first edge must not poison it
            wait_cnt <= (i_mem_req === 1'b1) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule // csr_vec_mem

// ===== verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam logic [31:0] SP_W = 32'h2000_1000;
    localparam logic [31:0] PC_W = 32'h0000_0101;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] dly = 4'h2;
    logic req, ack, run, sv, hm, tbit, pm, sps;
    logic we = 1'b0, push = 1'b0, pop = 1'b0, srwr = 1'b0, pcwe = 1'b0;
    logic tld = 1'b0, fwe = 1'b0, ent = 1'b0, ret = 1'b0;
    logic [3:0] wa = 4'h0, ra = 4'h0, flg = 4'h0;
    logic [5:0] enum_in = 6'h00;
    logic [7:0] ssel = 8'h00;
    logic [31:0] addr, rd, wd = '0, pcw = '0, pc, lnk, pd = '0, sa, sdat;
    logic [31:0] swd = '0, srd, vec = '0, rpsr = '0, asp, stw, v;
    int bad_count = 0;
    int check_count = 0;

    always #2.5 clk = ~clk;

    csr_vec_mem #(.SP_WORD(SP_W), .PC_WORD(PC_W)) csr_vec_mem_inst (
        .i_sys_clk(clk), .i_delay(dly), .i_mem_req(req), .i_mem_addr(addr),
        .o_mem_ack(ack), .o_mem_rdata(rd));

    csr_core_state csr_core_state_inst (
        .i_sys_clk(clk), .i_nrst(nrst), .o_mem_req(req), .o_mem_addr(addr),
        .i_mem_ack(ack), .i_mem_rdata(rd), .o_core_run(run),
        .i_reg_we(we), .i_reg_waddr(wa), .i_reg_wdata(wd),
        .i_reg_raddr(ra), .o_reg_rdata(v), .i_pc_we(pcwe),
        .i_pc_wdata(pcw), .i_pc_tload(tld), .o_program_counter(pc),
        .o_return_link(lnk), .i_push(push), .i_push_data(pd), .i_pop(pop),
        .o_store_valid(sv), .o_store_addr(sa), .o_store_data(sdat),
        .i_flags_we(fwe), .i_flags(flg), .i_sr_wr(srwr), .i_sr_sel(ssel),
        .i_sr_wdata(swd), .o_sr_rdata(srd), .i_exc_entry(ent),
        .i_exc_num(enum_in), .i_exc_vector(vec), .i_exc_return(ret),
        .i_ret_status(rpsr), .o_handler_mode(hm), .o_active_sp(asp),
        .o_combined_status_word(stw), .o_tbit(tbit), .o_exc_mask(pm),
        .o_spsel(sps));

    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check32(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check1(string name, logic exp, logic got);
        check32(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic sr_write(logic [7:0] sel, logic [31:0] data);
        @(posedge clk);
        srwr <= 1'b1;
        ssel <= sel;
        swd <= data;
        @(posedge clk);
        srwr <= 1'b0;
        #1;
    endtask

    task automatic sr_check(logic [7:0] sel, logic [31:0] exp);
        @(posedge clk);
        ssel <= sel;
        @(posedge clk);
        #1;
        check32("status view", exp, srd);
    endtask

    task automatic reset_core();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 40 && run !== 1'b1; i++) begin
            @(posedge clk);
        end
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_boot();
        check1("run", 1'b1, run);
        check32("first fetch", 32'h0, csr_vec_mem_inst.log_addr[0]);
        check32("second fetch", 32'h4, csr_vec_mem_inst.log_addr[1]);
        check32("main sp", SP_W, asp);
        check32("pc", PC_W & ~32'h1, pc);
        check32("link", 32'hffff_ffff, lnk);
        check1("state bit", 1'b1, tbit);
        check32("status word", 32'h0100_0000, stw);
        check1("handler", 1'b0, hm);
        check1("spsel", 1'b0, sps);
        check1("exception mask", 1'b0, pm);
        $display("test boot done");
    endtask

    task automatic t_regs();
        logic [31:0] val;
        for (int i = 0; i < 16; i += (i == 0) ? 12 : 1) begin
            val = (i == 13) ? SP_W + 32'h10 : 32'hc0de_0000 + i;
            @(posedge clk);
            we <= 1'b1;
            wa <= i[3:0];
            wd <= val;
            @(posedge clk);
            we <= 1'b0;
            ra <= i[3:0];
            @(posedge clk);
            #1;
            check32("core reg", val & ~{31'h0, i == 15}, v);
        end
        sr_write(csr_pkg::SR_MAIN_SP, SP_W);
        check32("main sp write", SP_W, asp);
        $display("test regs done");
    endtask

    task automatic t_stack();
        @(posedge clk);
        push <= 1'b1;
        pd <= 32'h1234_5678;
        @(posedge clk);
        @(posedge clk);
        push <= 1'b0;
        #1;
        check1("store pulse", 1'b1, sv);
        check32("store addr", SP_W - 32'h8, sa);
        check32("store data", 32'h1234_5678, sdat);
        check32("sp after push", SP_W - 32'h8, asp);
        @(posedge clk);
        pop <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        pop <= 1'b0;
        #1;
        check32("sp after pop", SP_W, asp);
        $display("test stack done");
    endtask

    task automatic t_modes();
        sr_write(csr_pkg::SR_PROC_SP, 32'h2000_0800);
        sr_check(csr_pkg::SR_PROC_SP, 32'h2000_0800);
        sr_write(csr_pkg::SR_CONTROL, 32'h0000_0002);
        sr_check(csr_pkg::SR_CONTROL, 32'h0000_0002);
        check32("process sp", 32'h2000_0800, asp);
        @(posedge clk);
        ent <= 1'b1;
        enum_in <= 6'h10;
        vec <= 32'h0000_0201;
        @(posedge clk);
        ent <= 1'b0;
        #1;
        check1("handler", 1'b1, hm);
        check32("handler sp", SP_W, asp);
        check32("exc field", 32'h0100_0010, stw);
        check32("entry pc", 32'h0000_0200, pc);
        sr_write(csr_pkg::SR_FLAGS, 32'hf000_0000);
        for (int s = 0; s < 8; s++) begin
            sr_check(s[7:0], s == 4 ? 32'h0 :
                (s[2] ? 32'h0 : 32'hf000_0000) | (s[0] ? 32'h10 : 32'h0));
        end
        sr_write(csr_pkg::SR_ALL, 32'h0000_003f);
        sr_write(csr_pkg::SR_STATE, 32'h0000_0000);
        check32("full write", 32'h0100_0010, stw);
        check1("state kept", 1'b1, tbit);
        @(posedge clk);
        ret <= 1'b1;
        rpsr <= 32'h6100_0000;
        @(posedge clk);
        ret <= 1'b0;
        #1;
        check1("thread again", 1'b0, hm);
        check32("thread sp", 32'h2000_0800, asp);
        check32("restored", 32'h6100_0000, stw);
        sr_write(csr_pkg::SR_CONTROL, 32'h0000_0000);
        check32("main again", SP_W, asp);
        $display("test modes done");
    endtask

    task automatic t_pc_flags();
        @(posedge clk);
        pcwe <= 1'b1;
        tld <= 1'b1;
        pcw <= 32'h0000_0300;
        fwe <= 1'b1;
        flg <= 4'h5;
        @(posedge clk);
        pcwe <= 1'b0;
        fwe <= 1'b0;
        #1;
        check32("pc load", 32'h0000_0300, pc);
        check1("state clear", 1'b0, tbit);
        sr_check(csr_pkg::SR_FLAGS, 32'h5000_0000);
        sr_write(csr_pkg::SR_EXC_MASK, 32'h0000_0001);
        check1("exception mask", 1'b1, pm);
        sr_check(csr_pkg::SR_EXC_MASK, 32'h0000_0001);
        $display("test pc flags done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        reset_core();
        t_boot();
        t_regs();
        t_stack();
        t_modes();
        t_pc_flags();
        dly <= 4'h0;
        reset_core();
        t_boot();
        wrap_up();
    end

    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule // testbench
